//--- inc/mcc_carrier_if.sv
// Carrier timing link between the configuration core and the carrier timer.
`timescale 1ns/1ps
`default_nettype none
interface mcc_carrier_if;
	logic [15:0] period;
	logic        asym;
	logic        enable;
	logic        update;
	logic [15:0] count;
	modport ctrl (output period, output asym, output enable, input update, input count);
	modport timer (input period, input asym, input enable, output update, output count);
endinterface
`default_nettype wire

//--- inc/mcc_pkg.sv
// Constants, register map and types for the motor control configuration block.
`default_nettype none
package mcc_pkg;
	localparam int CLK_MHZ      = 25;
	localparam int CONV_MAX_NS  = 8500;
	localparam int CONV_MAX_CYC = (CONV_MAX_NS * CLK_MHZ) / 1000;
	localparam int SCALE_SHIFT  = 12;

	localparam logic [7:0] OFS_CTRL       = 8'h00;
	localparam logic [7:0] OFS_HOST_REF   = 8'h04;
	localparam logic [7:0] OFS_REF_SCALE  = 8'h08;
	localparam logic [7:0] OFS_VQ_LIM     = 8'h0C;
	localparam logic [7:0] OFS_VD_LIM     = 8'h10;
	localparam logic [7:0] OFS_IQ_POS_LIM = 8'h14;
	localparam logic [7:0] OFS_IQ_NEG_LIM = 8'h18;
	localparam logic [7:0] OFS_SLIP_GAIN  = 8'h1C;
	localparam logic [7:0] OFS_COUNTER_EMF_IN    = 8'h20;
	localparam logic [7:0] OFS_COUNTER_EMF_GAIN  = 8'h24;
	localparam logic [7:0] OFS_VD_HOST    = 8'h28;
	localparam logic [7:0] OFS_PERIOD     = 8'h2C;
	localparam logic [7:0] OFS_STATUS     = 8'h30;
	localparam logic [7:0] OFS_IQ_CMD     = 8'h34;
	localparam logic [7:0] OFS_ANGLE      = 8'h38;

	localparam int CB_VEL_EN   = 0;
	localparam int CB_SLIP_EN  = 1;
	localparam int CB_REF_HOST = 2;
	localparam int CB_FB_ADC   = 3;
	localparam int CB_COUNTER_EMF_EN  = 4;
	localparam int CB_VD_EN    = 5;
	localparam int CB_ASYM     = 6;
	localparam int CB_TWO_PH   = 7;
	localparam int CB_HALL_IND = 8;
	localparam int CB_IDX_POL  = 9;
	localparam int CB_TQ_EN    = 10;
	localparam int CB_PWM_EN   = 11;
	localparam int CTRL_W      = 12;

	localparam logic [11:0] CTRL_RST       = 12'h020;
	localparam logic [15:0] REF_SCALE_RST  = 16'h1000;
	localparam logic [15:0] LIM_RST        = 16'h3FFF;
	localparam logic [15:0] IQ_NEG_LIM_RST = 16'hC001;
	localparam logic [15:0] PERIOD_RST     = 16'h04E2;

	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [1:0] {MCC_CV_IDLE, MCC_CV_WAIT} mcc_conv_t;
endpackage
`default_nettype wire

//--- rtl/mcc_carrier.sv
// PWM carrier counter that paces the current loop recomputation.
`timescale 1ns/1ps
`default_nettype none
module mcc_carrier
	import mcc_pkg::*;
(
	// Clock and reset.
	input wire logic     aclk,
	input wire logic     aresetn,
	// Carrier link.
	mcc_carrier_if.timer cif
);
	typedef struct packed {
		logic [15:0] cnt;
		logic        update;
	} mcc_car_st_t;

	mcc_car_st_t st_r;
	mcc_car_st_t st_nxt;

	always_comb begin
		st_nxt = st_r;
		st_nxt.update = 1'b0;
		if (!cif.enable) begin
			st_nxt.cnt = 16'h0000;
		end else begin
			// A period written below the current count would not be met until rollover, so the counter wraps on any count at or past period minus one.
			if (st_r.cnt >= cif.period - 16'h0001) begin
				st_nxt.cnt = 16'h0000;
			end else begin
				st_nxt.cnt = st_r.cnt + 16'h0001;
			end
			if (st_r.cnt == 16'h0000) begin
				st_nxt.update = 1'b1;
			end else if (cif.asym && st_r.cnt == (cif.period >> 1)) begin
				st_nxt.update = 1'b1;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign cif.update = st_r.update;
	assign cif.count  = st_r.cnt;
endmodule
`default_nettype wire

//--- rtl/mcc_config.sv
// Configuration switches, limits and reference routing of the field-oriented control path.
//
// The AXI4-Lite slave port and the register addresses were decided locally.
`timescale 1ns/1ps
`default_nettype none
// Operation
// - Velocity switch makes reference torque or velocity
// - Slip enable adds slip path to angle
// - Slip path input is q-axis current command
// - Reference comes from converter or host register
// - Analog reference made signed, then scaled
// - High-voltage front end: 10-bit, 8.5 us
// - Converter front end: both phases, 12-bit
// - Counter-EMF gain output adds to q regulator
// - d regulator off: host value drives d voltage
// - q and d outputs clamped to symmetric limits
// - Speed regulator output clamped to separate limits
// - Two/three phase and symmetric/asymmetric PWM selectable
// - Hall input type and index polarity selectable
// - Loop recomputed once or twice per carrier
module mcc_config
	import mcc_pkg::*;
(
	// Clock and reset.
	input  wire logic        aclk,
	input  wire logic        aresetn,
	// AXI4-Lite slave.
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	// Reference converter and regulator outputs.
	input  wire logic [11:0] analog_ref,
	input  wire logic        analog_ref_valid,
	input  wire logic [15:0] speed_reg_out,
	input  wire logic [15:0] torque_current_reg_out,
	input  wire logic [15:0] field_current_reg_out,
	input  wire logic [15:0] encoder_angle,
	input  wire logic        index_pulse_in,
	// Current feedback front ends.
	input  wire logic [9:0]  hv_fb_v,
	input  wire logic [9:0]  hv_fb_w,
	input  wire logic        hv_fb_valid,
	input  wire logic [11:0] adc_fb_v,
	input  wire logic [11:0] adc_fb_w,
	input  wire logic        adc_fb_valid,
	// Commands to the control path.
	output logic [15:0]      torque_command,
	output logic [15:0]      velocity_command,
	output logic [15:0]      torque_current_command,
	output logic [15:0]      vq_command,
	output logic [15:0]      vd_command,
	output logic [15:0]      rotor_angle,
	output logic [11:0]      phase_fb_v,
	output logic [11:0]      phase_fb_w,
	output logic             phase_fb_valid,
	output logic             conv_start,
	output logic             fb_select_adc,
	output logic             control_update,
	// PWM and encoder configuration.
	output logic             pwm_enable,
	output logic             pwm_asym,
	output logic             two_phase_mod,
	output logic             hall_independent,
	output logic             index_pulse_out
);
	typedef struct packed {
		logic              awready;
		logic              wready;
		logic              aw_done;
		logic              w_done;
		logic [7:0]        waddr;
		logic [31:0]       wdata;
		logic [3:0]        wstrb;
		logic              bvalid;
		logic [1:0]        bresp;
		logic              arready;
		logic              rvalid;
		logic [31:0]       rdata;
		logic [1:0]        rresp;
		logic [CTRL_W-1:0] ctrl;
		logic [15:0]       host_ref;
		logic [15:0]       ref_scale;
		logic [15:0]       vq_lim;
		logic [15:0]       vd_lim;
		logic [15:0]       iq_pos_lim;
		logic [15:0]       iq_neg_lim;
		logic [15:0]       slip_gain;
		logic [15:0]       counter_emf_in;
		logic [15:0]       counter_emf_gain;
		logic [15:0]       vd_host;
		logic [15:0]       period;
		logic              conv_timeout;
		logic [15:0]       ref_val;
		logic [15:0]       torque_ref;
		logic [15:0]       velocity_ref;
		logic [15:0]       iq_cmd;
		logic [15:0]       vq_cmd;
		logic [15:0]       vd_cmd;
		logic [15:0]       slip_acc;
		logic [15:0]       angle;
		logic [11:0]       fb_v;
		logic [11:0]       fb_w;
		logic              fb_valid;
		logic              conv_start;
		mcc_conv_t         conv;
		logic [7:0]        conv_cnt;
		logic              update;
		logic              index_out;
	} mcc_cfg_st_t;

	mcc_cfg_st_t   st_r;
	mcc_cfg_st_t   st_nxt;
	mcc_carrier_if cif ();

	mcc_carrier u_carrier (
		.aclk    (aclk),
		.aresetn (aresetn),
		.cif     (cif)
	);

	assign cif.period = st_r.period;
	assign cif.asym   = st_r.ctrl[CB_ASYM];
	assign cif.enable = st_r.ctrl[CB_PWM_EN];

	function automatic logic [15:0] clamp(input logic signed [31:0] v,
			input logic signed [15:0] hi, input logic signed [15:0] lo);
		logic signed [31:0] h;
		logic signed [31:0] l;
		h = 32'(hi);
		l = 32'(lo);
		if (v > h) begin
			return hi;
		end else if (v < l) begin
			return lo;
		end
		return v[15:0];
	endfunction

	// Gains are fixed point with 4096 as unity.
	function automatic logic signed [31:0] scale(input logic signed [15:0] a,
			input logic signed [15:0] g);
		logic signed [31:0] p;
		p = 32'(a) * 32'(g);
		return p >>> SCALE_SHIFT;
	endfunction

	function automatic logic [15:0] merge(input logic [15:0] old, input logic [31:0] d,
			input logic [3:0] s);
		logic [15:0] r;
		r = old;
		if (s[0]) begin
			r[7:0] = d[7:0];
		end
		if (s[1]) begin
			r[15:8] = d[15:8];
		end
		return r;
	endfunction

	always_comb begin
		logic signed [15:0] ref_s;
		logic signed [15:0] vq_pos;
		logic signed [15:0] vd_pos;
		logic signed [31:0] vq_sum;
		logic               wr_go;
		logic               ok;
		ref_s  = '0;
		vq_pos = '0;
		vd_pos = '0;
		vq_sum = '0;
		wr_go  = 1'b0;
		ok     = 1'b1;
		st_nxt = st_r;

		// Write channel: address and data are taken in either order, one write at a time.
		if (s_axi_awvalid && st_r.awready) begin
			st_nxt.aw_done = 1'b1;
			st_nxt.waddr   = s_axi_awaddr;
		end
		if (s_axi_wvalid && st_r.wready) begin
			st_nxt.w_done = 1'b1;
			st_nxt.wdata  = s_axi_wdata;
			st_nxt.wstrb  = s_axi_wstrb;
		end
		if (st_r.bvalid && s_axi_bready) begin
			st_nxt.bvalid = 1'b0;
		end
		wr_go = st_r.aw_done && st_r.w_done && !st_r.bvalid;
		if (wr_go) begin
			st_nxt.aw_done = 1'b0;
			st_nxt.w_done  = 1'b0;
			st_nxt.bvalid  = 1'b1;
			unique case (st_r.waddr)
				OFS_CTRL: begin
					st_nxt.ctrl[7:0] = st_r.wstrb[0] ? st_r.wdata[7:0] : st_r.ctrl[7:0];
					if (st_r.wstrb[1]) begin
						st_nxt.ctrl[CTRL_W-1:8] = st_r.wdata[CTRL_W-1:8];
					end
				end
				OFS_HOST_REF:   st_nxt.host_ref   = merge(st_r.host_ref, st_r.wdata, st_r.wstrb);
				OFS_REF_SCALE:  st_nxt.ref_scale  = merge(st_r.ref_scale, st_r.wdata, st_r.wstrb);
				OFS_VQ_LIM:     st_nxt.vq_lim     = merge(st_r.vq_lim, st_r.wdata, st_r.wstrb);
				OFS_VD_LIM:     st_nxt.vd_lim     = merge(st_r.vd_lim, st_r.wdata, st_r.wstrb);
				OFS_IQ_POS_LIM: st_nxt.iq_pos_lim = merge(st_r.iq_pos_lim, st_r.wdata, st_r.wstrb);
				OFS_IQ_NEG_LIM: st_nxt.iq_neg_lim = merge(st_r.iq_neg_lim, st_r.wdata, st_r.wstrb);
				OFS_SLIP_GAIN:  st_nxt.slip_gain  = merge(st_r.slip_gain, st_r.wdata, st_r.wstrb);
				OFS_COUNTER_EMF_IN:    st_nxt.counter_emf_in    = merge(st_r.counter_emf_in, st_r.wdata, st_r.wstrb);
				OFS_COUNTER_EMF_GAIN:  st_nxt.counter_emf_gain  = merge(st_r.counter_emf_gain, st_r.wdata, st_r.wstrb);
				OFS_VD_HOST:    st_nxt.vd_host    = merge(st_r.vd_host, st_r.wdata, st_r.wstrb);
				OFS_PERIOD:     st_nxt.period     = merge(st_r.period, st_r.wdata, st_r.wstrb);
				OFS_STATUS: begin
					if (st_r.wstrb[0] && st_r.wdata[0]) begin
						st_nxt.conv_timeout = 1'b0;
					end
				end
				OFS_IQ_CMD, OFS_ANGLE: begin
				end
				default: ok = 1'b0;
			endcase
			st_nxt.bresp = ok ? RESP_OKAY : RESP_SLVERR;
		end
		st_nxt.awready = !st_nxt.aw_done && !st_nxt.bvalid;
		st_nxt.wready  = !st_nxt.w_done && !st_nxt.bvalid;

		// Read channel.
		if (st_r.rvalid && s_axi_rready) begin
			st_nxt.rvalid = 1'b0;
		end
		if (s_axi_arvalid && st_r.arready) begin
			st_nxt.rvalid = 1'b1;
			st_nxt.rresp  = RESP_OKAY;
			st_nxt.rdata  = 32'h0000_0000;
			unique case (s_axi_araddr)
				OFS_CTRL:       st_nxt.rdata[CTRL_W-1:0] = st_r.ctrl;
				OFS_HOST_REF:   st_nxt.rdata[15:0] = st_r.host_ref;
				OFS_REF_SCALE:  st_nxt.rdata[15:0] = st_r.ref_scale;
				OFS_VQ_LIM:     st_nxt.rdata[15:0] = st_r.vq_lim;
				OFS_VD_LIM:     st_nxt.rdata[15:0] = st_r.vd_lim;
				OFS_IQ_POS_LIM: st_nxt.rdata[15:0] = st_r.iq_pos_lim;
				OFS_IQ_NEG_LIM: st_nxt.rdata[15:0] = st_r.iq_neg_lim;
				OFS_SLIP_GAIN:  st_nxt.rdata[15:0] = st_r.slip_gain;
				OFS_COUNTER_EMF_IN:    st_nxt.rdata[15:0] = st_r.counter_emf_in;
				OFS_COUNTER_EMF_GAIN:  st_nxt.rdata[15:0] = st_r.counter_emf_gain;
				OFS_VD_HOST:    st_nxt.rdata[15:0] = st_r.vd_host;
				OFS_PERIOD:     st_nxt.rdata[15:0] = st_r.period;
				OFS_STATUS: begin
					st_nxt.rdata[0]     = st_r.conv_timeout;
					st_nxt.rdata[1]     = st_r.conv == MCC_CV_WAIT;
					st_nxt.rdata[31:16] = cif.count;
				end
				OFS_IQ_CMD:     st_nxt.rdata[15:0] = st_r.iq_cmd;
				OFS_ANGLE:      st_nxt.rdata[15:0] = st_r.angle;
				default:        st_nxt.rresp = RESP_SLVERR;
			endcase
		end
		st_nxt.arready = !st_nxt.rvalid;

		// Reference routing and scaling.
		if (st_r.ctrl[CB_REF_HOST]) begin
			st_nxt.ref_val = st_r.host_ref;
		end else if (analog_ref_valid) begin
			ref_s = 16'($signed({~analog_ref[11], analog_ref[10:0]}));
			st_nxt.ref_val = clamp(scale(ref_s, $signed(st_r.ref_scale)), 16'sh7FFF,
				-16'sh7FFF);
		end
		if (st_r.ctrl[CB_VEL_EN]) begin
			st_nxt.velocity_ref = st_r.ref_val;
			st_nxt.iq_cmd = clamp(32'($signed(speed_reg_out)), $signed(st_r.iq_pos_lim),
				$signed(st_r.iq_neg_lim));
		end else begin
			st_nxt.velocity_ref = 16'h0000;
			st_nxt.iq_cmd = st_r.ref_val;
		end
		st_nxt.torque_ref = st_nxt.iq_cmd;

		// Regulator outputs, feedforward and open-loop override.
		vq_pos = $signed(st_r.vq_lim);
		vd_pos = $signed(st_r.vd_lim);
		vq_sum = 32'($signed(clamp(32'($signed(torque_current_reg_out)), vq_pos,
			-vq_pos)));
		if (st_r.ctrl[CB_COUNTER_EMF_EN]) begin
			vq_sum = vq_sum + scale($signed(st_r.counter_emf_in), $signed(st_r.counter_emf_gain));
		end
		st_nxt.vq_cmd = clamp(vq_sum, 16'sh7FFF, -16'sh7FFF);
		if (st_r.ctrl[CB_VD_EN]) begin
			st_nxt.vd_cmd = clamp(32'($signed(field_current_reg_out)), vd_pos, -vd_pos);
		end else begin
			st_nxt.vd_cmd = st_r.vd_host;
		end
		// Torque control off leaves both voltage commands at zero.
		if (!st_r.ctrl[CB_TQ_EN]) begin
			st_nxt.vq_cmd = 16'h0000;
			st_nxt.vd_cmd = 16'h0000;
		end

		// Slip advances once per loop update; the angle wraps by design.
		st_nxt.update = cif.update;
		if (!st_r.ctrl[CB_SLIP_EN]) begin
			st_nxt.slip_acc = 16'h0000;
		end else if (st_r.update) begin
			st_nxt.slip_acc = st_r.slip_acc + 16'(scale($signed(st_r.iq_cmd),
				$signed(st_r.slip_gain)));
		end
		st_nxt.angle = encoder_angle + st_r.slip_acc;

		// Current feedback conversion, started by a loop update that finds no conversion pending.
		st_nxt.conv_start = 1'b0;
		st_nxt.fb_valid   = 1'b0;
		unique case (st_r.conv)
			MCC_CV_IDLE: begin
				if (st_r.update) begin
					st_nxt.conv_start = 1'b1;
					st_nxt.conv       = MCC_CV_WAIT;
					st_nxt.conv_cnt   = 8'h00;
				end
			end
			MCC_CV_WAIT: begin
				st_nxt.conv_cnt = st_r.conv_cnt + 8'h01;
				if (st_r.ctrl[CB_FB_ADC] && adc_fb_valid) begin
					st_nxt.fb_v     = {~adc_fb_v[11], adc_fb_v[10:0]};
					st_nxt.fb_w     = {~adc_fb_w[11], adc_fb_w[10:0]};
					st_nxt.fb_valid = 1'b1;
					st_nxt.conv     = MCC_CV_IDLE;
				end else if (!st_r.ctrl[CB_FB_ADC] && hv_fb_valid) begin
					st_nxt.fb_v     = {hv_fb_v, 2'h0};
					st_nxt.fb_w     = {hv_fb_w, 2'h0};
					st_nxt.fb_valid = 1'b1;
					st_nxt.conv     = MCC_CV_IDLE;
				end else if (st_r.conv_cnt == 8'(CONV_MAX_CYC - 1)) begin
					st_nxt.conv_timeout = 1'b1;
					st_nxt.conv         = MCC_CV_IDLE;
				end
			end
		endcase

		st_nxt.index_out = index_pulse_in ^ st_r.ctrl[CB_IDX_POL];
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st_r            <= '0;
			st_r.awready    <= 1'b1;
			st_r.wready     <= 1'b1;
			st_r.arready    <= 1'b1;
			st_r.ctrl       <= CTRL_RST;
			st_r.ref_scale  <= REF_SCALE_RST;
			st_r.vq_lim     <= LIM_RST;
			st_r.vd_lim     <= LIM_RST;
			st_r.iq_pos_lim <= LIM_RST;
			st_r.iq_neg_lim <= IQ_NEG_LIM_RST;
			st_r.period     <= PERIOD_RST;
			st_r.conv       <= MCC_CV_IDLE;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign s_axi_awready          = st_r.awready;
	assign s_axi_wready           = st_r.wready;
	assign s_axi_bresp            = st_r.bresp;
	assign s_axi_bvalid           = st_r.bvalid;
	assign s_axi_arready          = st_r.arready;
	assign s_axi_rdata            = st_r.rdata;
	assign s_axi_rresp            = st_r.rresp;
	assign s_axi_rvalid           = st_r.rvalid;
	assign torque_command         = st_r.torque_ref;
	assign velocity_command       = st_r.velocity_ref;
	assign torque_current_command = st_r.iq_cmd;
	assign vq_command             = st_r.vq_cmd;
	assign vd_command             = st_r.vd_cmd;
	assign rotor_angle            = st_r.angle;
	assign phase_fb_v             = st_r.fb_v;
	assign phase_fb_w             = st_r.fb_w;
	assign phase_fb_valid         = st_r.fb_valid;
	assign conv_start             = st_r.conv_start;
	assign fb_select_adc          = st_r.ctrl[CB_FB_ADC];
	assign control_update         = st_r.update;
	assign pwm_enable             = st_r.ctrl[CB_PWM_EN];
	assign pwm_asym               = st_r.ctrl[CB_ASYM];
	assign two_phase_mod          = st_r.ctrl[CB_TWO_PH];
	assign hall_independent       = st_r.ctrl[CB_HALL_IND];
	assign index_pulse_out        = st_r.index_out;
endmodule
`default_nettype wire

//--- verif/mcc_config_sva.sv
// Port-level checks of the configuration block.
`timescale 1ns/1ps
`default_nettype none
module mcc_config_sva
	import mcc_pkg::*;
(
	// Clock and reset.
	input wire logic        aclk,
	input wire logic        aresetn,
	// Bus answers.
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_bready,
	input wire logic        s_axi_rvalid,
	input wire logic        s_axi_rready,
	// Commands and feedback.
	input wire logic [15:0] torque_command,
	input wire logic [15:0] torque_current_command,
	input wire logic        control_update,
	input wire logic        conv_start,
	input wire logic [9:0]  hv_fb_v,
	input wire logic        hv_fb_valid,
	input wire logic [11:0] adc_fb_v,
	input wire logic        adc_fb_valid,
	input wire logic        fb_select_adc,
	input wire logic [11:0] phase_fb_v,
	input wire logic        phase_fb_valid
);
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	property p_cmd_pair;
		torque_command == torque_current_command;
	endproperty
	a_cmd_pair: assert property (p_cmd_pair) else $error("torque command split");
	property p_upd_pulse;
		control_update |=> !control_update;
	endproperty
	a_upd_pulse: assert property (p_upd_pulse) else $error("update too long");
	property p_conv_cause;
		conv_start |-> $past(control_update);
	endproperty
	a_conv_cause: assert property (p_conv_cause) else $error("start without update");
	property p_hv_fmt;
		phase_fb_valid && !$past(fb_select_adc) |->
			$past(hv_fb_valid) && phase_fb_v == {$past(hv_fb_v), 2'b00};
	endproperty
	a_hv_fmt: assert property (p_hv_fmt) else $error("bad sense result");
	property p_adc_fmt;
		phase_fb_valid && $past(fb_select_adc) |->
			$past(adc_fb_valid) && phase_fb_v == ($past(adc_fb_v) ^ 12'h800);
	endproperty
	a_adc_fmt: assert property (p_adc_fmt) else $error("bad converter result");
	property p_fb_hold;
		!phase_fb_valid |-> $stable(phase_fb_v);
	endproperty
	a_fb_hold: assert property (p_fb_hold) else $error("feedback moved");
	property p_b_done;
		s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid;
	endproperty
	a_b_done: assert property (p_b_done) else $error("write answer repeated");
	property p_r_done;
		s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid;
	endproperty
	a_r_done: assert property (p_r_done) else $error("read answer repeated");
	c_update: cover property (control_update);
	c_adc_fb: cover property (phase_fb_valid && fb_select_adc);
	c_write: cover property (s_axi_bvalid && s_axi_bready);
endmodule
bind mcc_config mcc_config_sva mcc_config_sva_inst (.*);
`default_nettype wire

//--- verif/mcc_config_tb_top.sv
// Self-checking bench for the motor control configuration block.
`timescale 1ns/1ps
`default_nettype none
module mcc_config_tb_top
	import mcc_pkg::*;
;
	localparam logic [31:0] VEL = 1 << CB_VEL_EN, SLP = 1 << CB_SLIP_EN;
	localparam logic [31:0] HREF = 1 << CB_REF_HOST, FADC = 1 << CB_FB_ADC;
	localparam logic [31:0] EMF = 1 << CB_COUNTER_EMF_EN, VDE = 1 << CB_VD_EN;
	localparam logic [31:0] ASY = 1 << CB_ASYM, TWO = 1 << CB_TWO_PH;
	localparam logic [31:0] HALL = 1 << CB_HALL_IND, IDX = 1 << CB_IDX_POL;
	localparam logic [31:0] TQ = 1 << CB_TQ_EN, PWM = 1 << CB_PWM_EN;
	logic        aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
	logic        s_axi_rready, analog_ref_valid, index_pulse_in, hv_fb_valid, adc_fb_valid;
	logic        phase_fb_valid, conv_start, fb_select_adc, control_update, pwm_enable;
	logic        pwm_asym, two_phase_mod, hall_independent, index_pulse_out, mute;
	logic [1:0]  s_axi_bresp, s_axi_rresp, resp;
	logic [3:0]  s_axi_wstrb;
	logic [4:0]  modes;
	logic [7:0]  s_axi_awaddr, s_axi_araddr;
	logic [8:0]  delay;
	logic [9:0]  hv_fb_v, hv_fb_w;
	logic [11:0] analog_ref, adc_fb_v, adc_fb_w, sample, phase_fb_v, phase_fb_w;
	logic [15:0] speed_reg_out, torque_current_reg_out, field_current_reg_out, encoder_angle;
	logic [15:0] torque_command, velocity_command, torque_current_command, vq_command;
	logic [15:0] vd_command, rotor_angle;
	logic [31:0] s_axi_wdata, s_axi_rdata, rd_data;
	int          fails = 0, check_count = 0, cycles = 0, t0;
	assign modes = {pwm_asym, two_phase_mod, hall_independent, fb_select_adc, index_pulse_out};
	mcc_config mcc_config_inst (.*);
	mcc_conv_model mcc_conv_model_inst (.*);
	initial begin
		aclk = 1'b0;
		forever #20 aclk = ~aclk;
	end
	task automatic conclude();
		$display("comparisons %0d, mismatches %0d", check_count, fails);
		if (fails == 0 && check_count > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	always @(posedge aclk) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			fails++;
			conclude();
		end
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			fails++;
			$display("[FAIL] %0t ns: saw %h, expected %h", $time, got, exp);
		end
	endtask
	task automatic wt(input int n);
		repeat (n) @(posedge aclk);
	endtask
	task automatic wfor(ref logic s);
		while (s !== 1'b1) @(posedge aclk);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge aclk);
		{s_axi_awaddr, s_axi_wdata} <= {a, d};
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'b111;
		do begin
			@(posedge aclk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
		end while ((s_axi_awvalid && !s_axi_awready) || (s_axi_wvalid && !s_axi_wready));
		do @(posedge aclk); while (!s_axi_bvalid);
		resp = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a);
		@(posedge aclk);
		s_axi_araddr <= a;
		{s_axi_arvalid, s_axi_rready} <= 2'b11;
		do @(posedge aclk); while (!s_axi_arready);
		s_axi_arvalid <= 1'b0;
		do @(posedge aclk); while (!s_axi_rvalid);
		{rd_data, resp} = {s_axi_rdata, s_axi_rresp};
		s_axi_rready <= 1'b0;
	endtask
	task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
		rd(a);
		chk(rd_data, exp);
	endtask
	task automatic gap(input int exp);
		wfor(control_update);
		t0 = cycles;
		@(posedge aclk);
		wfor(control_update);
		chk(32'(cycles - t0), 32'(exp));
	endtask
	initial begin
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = {16'h0000, 32'h0, 4'hF};
		{analog_ref, analog_ref_valid, index_pulse_in, speed_reg_out} = '0;
		{torque_current_reg_out, field_current_reg_out, encoder_angle} = '0;
		{delay, mute, sample} = '0;
		aresetn = 1'b0;
		wt(20);
		aresetn <= 1'b1;
		rdc(OFS_CTRL, 32'(CTRL_RST));
		rdc(OFS_REF_SCALE, 32'(REF_SCALE_RST));
		rdc(OFS_VD_LIM, 32'(LIM_RST));
		rdc(OFS_IQ_NEG_LIM, 32'(IQ_NEG_LIM_RST));
		rdc(OFS_PERIOD, 32'(PERIOD_RST));
		rdc(8'hFC, 32'h0);
		chk(32'(resp), 32'(RESP_SLVERR));
		wr(8'hFC, 32'h1);
		chk(32'(resp), 32'(RESP_SLVERR));
		$display("test reset done");
		wr(OFS_HOST_REF, 32'h0123);
		wr(OFS_CTRL, TQ | HREF | VDE);
		wt(4);
		chk(32'(torque_current_command), 32'h0123);
		chk(32'(velocity_command), 32'h0);
		speed_reg_out <= 16'h5000;
		wr(OFS_CTRL, TQ | HREF | VDE | VEL);
		wt(4);
		chk(32'(velocity_command), 32'h0123);
		chk(32'(torque_current_command), 32'h3FFF);
		speed_reg_out <= 16'h8000;
		wt(4);
		chk(32'(torque_current_command), 32'hC001);
		wr(OFS_IQ_POS_LIM, 32'h0100);
		wr(OFS_IQ_NEG_LIM, 32'hFF00);
		wt(4);
		chk(32'(torque_current_command), 32'hFF00);
		speed_reg_out <= 16'h0200;
		wt(4);
		chk(32'(torque_current_command), 32'h0100);
		wr(OFS_CTRL, TQ | VDE);
		{analog_ref, analog_ref_valid} <= {12'hC00, 1'b1};
		wt(1);
		analog_ref_valid <= 1'b0;
		wt(4);
		chk(32'(torque_current_command), 32'h0400);
		analog_ref <= 12'h200;
		wr(OFS_REF_SCALE, 32'h2000);
		wt(4);
		chk(32'(torque_current_command), 32'h0400);
		analog_ref_valid <= 1'b1;
		wt(1);
		analog_ref_valid <= 1'b0;
		wt(4);
		chk(32'(torque_current_command), 32'hF400);
		$display("test reference done");
		{torque_current_reg_out, field_current_reg_out} <= {16'h7000, 16'h9000};
		wt(4);
		chk(32'(vq_command), 32'h3FFF);
		chk(32'(vd_command), 32'hC001);
		wr(OFS_VQ_LIM, 32'h0100);
		torque_current_reg_out <= 16'h8000;
		wr(OFS_COUNTER_EMF_IN, 32'h0180);
		wr(OFS_COUNTER_EMF_GAIN, 32'h1000);
		wr(OFS_VD_HOST, 32'h0222);
		wt(4);
		chk(32'(vq_command), 32'hFF00);
		wr(OFS_CTRL, TQ | EMF);
		wt(4);
		chk(32'(vq_command), 32'h0080);
		chk(32'(vd_command), 32'h0222);
		index_pulse_in <= 1'b1;
		wr(OFS_CTRL, ASY | TWO | HALL | IDX | FADC);
		wt(2);
		chk(32'(modes), 32'h1E);
		wr(OFS_CTRL, VDE);
		wt(2);
		chk(32'(modes), 32'h01);
		$display("test switches done");
		{sample, delay} <= {12'h155, 9'd3};
		wr(OFS_PERIOD, 32'h0028);
		wr(OFS_CTRL, PWM | TQ | VDE);
		gap(40);
		chk(32'(pwm_enable), 32'h1);
		wfor(phase_fb_valid);
		chk(32'(phase_fb_v), 32'h554);
		chk(32'(phase_fb_w), 32'h558);
		wr(OFS_CTRL, TQ | VDE);
		delay <= 9'd150;
		wr(OFS_CTRL, PWM | TQ | VDE | FADC | ASY);
		gap(20);
		wfor(phase_fb_valid);
		chk(32'(phase_fb_v), 32'h955);
		chk(32'(phase_fb_w), 32'h956);
		mute <= 1'b1;
		wt(300);
		wr(OFS_CTRL, TQ | VDE | FADC);
		wt(250);
		rd(OFS_STATUS);
		chk(rd_data & 32'h1, 32'h1);
		wr(OFS_STATUS, 32'h1);
		rd(OFS_STATUS);
		chk(rd_data & 32'h1, 32'h0);
		mute <= 1'b0;
		$display("test feedback done");
		encoder_angle <= 16'h1000;
		wr(OFS_SLIP_GAIN, 32'h1000);
		wr(OFS_CTRL, TQ | VDE | HREF | SLP);
		wt(4);
		chk(32'(rotor_angle), 32'h1000);
		wr(OFS_CTRL, PWM | TQ | VDE | HREF | SLP);
		gap(40);
		wr(OFS_CTRL, TQ | VDE | HREF | SLP);
		wt(4);
		chk(32'((rotor_angle - 16'h1000) % 16'h0123), 32'h0);
		chk(32'(rotor_angle == 16'h1000), 32'h0);
		wr(OFS_CTRL, TQ | VDE | HREF);
		wt(4);
		chk(32'(rotor_angle), 32'h1000);
		$display("test slip done");
		conclude();
	end
endmodule
`default_nettype wire

//--- verif/mcc_conv_model.sv
// Behavioural model of the two current-sense front ends.
`timescale 1ns/1ps
`default_nettype none
module mcc_conv_model
	import mcc_pkg::*;
(
	// Clock and reset.
	input  wire logic        aclk,
	input  wire logic        aresetn,
	// Request and answer settings.
	input  wire logic        conv_start,
	input  wire logic [8:0]  delay,
	input  wire logic        mute,
	input  wire logic [11:0] sample,
	// Results.
	output logic [9:0]       hv_fb_v,
	output logic [9:0]       hv_fb_w,
	output logic             hv_fb_valid,
	output logic [11:0]      adc_fb_v,
	output logic [11:0]      adc_fb_w,
	output logic             adc_fb_valid
);
	int cnt;
	always @(posedge aclk) begin
		{hv_fb_valid, adc_fb_valid} <= 2'b00;
		{hv_fb_v, hv_fb_w, adc_fb_v, adc_fb_w} <= ~{hv_fb_v, hv_fb_w, adc_fb_v, adc_fb_w};
		if (!aresetn) begin
			cnt <= -1;
			{hv_fb_v, hv_fb_w, adc_fb_v, adc_fb_w} <= '0;
		end else if (conv_start) begin
			cnt <= int'(delay);
		end else if (cnt == 0 && !mute) begin
			hv_fb_v  <= sample[9:0];
			hv_fb_w  <= sample[9:0] + 10'h001;
			adc_fb_v <= sample;
			adc_fb_w <= sample + 12'h001;
			{hv_fb_valid, adc_fb_valid} <= 2'b11;
		end
		if (aresetn && cnt >= 0 && !conv_start) cnt <= cnt - 1;
	end
endmodule
`default_nettype wire
